// [dv/pdio_ext_model.sv]
`timescale 1ns/100ps
module pdio_ext_model (
    input wire clk_i,
    input wire [1:0] pin_o,
    input wire [1:0] pin_oe_o,
    input wire [1:0] pull_low_i,
    output wire [1:0] pin_i,
    output reg [15:0] low_len
);
    reg [15:0] run = 16'h0;
    // Pull-up keeps released pins high; pulses only ever go low
    assign pin_i = ~pull_low_i & (~pin_oe_o | pin_o);
    // Width of the last low phase on pin one
    always @(posedge clk_i) begin
        run <= pin_i[0] ? 16'h0 : run + 16'h1;
        if (pin_i[0] && run != 16'h0) begin
            low_len <= run;
        end
    end
endmodule // pdio_ext_model

// [dv/pdio_properties.sv]
`timescale 1ns/100ps
module pdio_props (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire on_switch_i,
    input wire prot_active_o,
    input wire prot_clear_o,
    input wire [1:0] pin_i,
    input wire [1:0] pin_o,
    input wire [1:0] pin_oe_o
);
    reg [15:0] ctl;
    reg [1:0] age;
    reg [15:0] hi_n;
    reg [15:0] run;
    reg [15:0] last;
    wire cw = wb_ack_o & wb_cyc_i & wb_we_i & (wb_adr_i == 8'h00);
    wire low = ~(pin_i[0] ^ ctl[2]);
    // Shadow of the control register; age hides the one-cycle output lag
    always @(posedge clk_i) begin
        age <= (rst_i || cw) ? 2'h0 : age + {1'b0, age != 2'h3};
        if (rst_i) begin
            ctl <= 16'h0;
        end else if (cw) begin
            ctl <= {wb_sel_i[1] ? wb_dat_i[15:8] : ctl[15:8],
                    wb_sel_i[0] ? wb_dat_i[7:0] : ctl[7:0]};
        end
        hi_n <= pin_oe_o[0] ? hi_n + 16'h1 : 16'h0;
        run <= low ? run + 16'h1 : 16'h0;
        if (low) begin
            last <= run + 16'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_lat_a: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bad ack timing");
    clr_cause_a: assert property (prot_clear_o |-> $past(prot_active_o) && !prot_active_o)
        else $error("clear without protection");
    clr_width_a: assert property (prot_clear_o |-> last >= 16'd1200)
        else $error("clear after short low");
    st_level_a: assert property (ctl[9:8] == 2'h0 && age == 2'h3 |->
        pin_oe_o[1] && pin_o[1] == (!$past(prot_active_o) ^ ctl[10]))
        else $error("bad status level");
    out_level_a: assert property (ctl[9:8] == 2'h2 && !ctl[12] && age == 2'h3 |->
        pin_oe_o[1] && pin_o[1] == (ctl[10] ~^ ctl[11]))
        else $error("bad output level");
    pulse_low_a: assert property (ctl[1:0] == 2'h0 && age == 2'h3 && pin_oe_o[0] |->
        pin_o[0] == ctl[2])
        else $error("pulse not low going");
    pulse_len_a: assert property (ctl[1:0] == 2'h0 && age == 2'h3 && $fell(pin_oe_o[0]) |->
        hi_n == 16'd1200)
        else $error("bad pulse width");
    pulse_go_a: assert property ($rose(on_switch_i) && !prot_active_o && ctl[1:0] == 2'h0
        && age == 2'h3 && !pin_oe_o[0] |-> ##[1:3] pin_oe_o[0])
        else $error("no pulse on switch on");
endmodule // pdio_props
bind pdio_top pdio_props u_props (.*);

// [dv/testbench.sv]
`timescale 1ns/100ps
`define chk(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0;
    reg trip = 1'b0;
    reg on_sw = 1'b0;
    reg [1:0] pull = 2'h0;
    wire [31:0] rdat;
    wire ack, prot, clr;
    wire [1:0] pin_w, pin_o, oe;
    wire [15:0] low_len;
    integer err_count = 0;
    integer checks_done = 0;
    integer cyc_n = 0;
    integer p, d, n, k, i;
    reg [31:0] q;
    pdio_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .prot_trip_i(trip), .on_switch_i(on_sw), .prot_active_o(prot), .prot_clear_o(clr),
        .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(oe));
    pdio_ext_model ext (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(oe), .pull_low_i(pull),
        .pin_i(pin_w), .low_len(low_len));
    initial forever #12.5 clk_i = ~clk_i;
    task end_of_test;
        begin
            if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 20000) begin
            err_count++;
            end_of_test;
        end
    end
    task wait_n(input integer c);
        repeat (c) @(posedge clk_i);
    endtask
    task wb(input [7:0] a, input w, input [31:0] v);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= v;
            @(posedge clk_i);
            while (ack !== 1'b1) @(posedge clk_i);
            q = rdat;
            cyc <= 1'b0;
        end
    endtask
    // Low pulse from the far instrument on pin one
    task pulse(input integer w);
        begin
            pull <= 2'h1;
            wait_n(w);
            pull <= 2'h0;
            wait_n(20);
        end
    endtask
    task do_trip;
        begin
            trip <= 1'b1;
            wait_n(1);
            trip <= 1'b0;
            wait_n(3);
        end
    endtask
    function lvl(input inv, input tru);
        lvl = inv ~^ tru;
    endfunction
    initial begin
        p = $urandom(71);
        wait_n(5);
        rst_i <= 1'b0;
        wb(8'h00, 1'b0, 32'h0);
        `chk("ctrl", 32'h0, q)
        wb(8'h1c, 1'b1, 32'hffffffff);
        wb(8'h1c, 1'b0, 32'h0);
        `chk("unmapped", 32'h0, q)
        `chk("pin2", 1'b1, pin_w[1])
        on_sw <= 1'b1;
        wait_n(1300);
        `chk("pulse", 16'd1200, low_len)
        on_sw <= 1'b0;
        do_trip;
        `chk("pin2", 1'b0, pin_w[1])
        pulse(1190);
        `chk("short", 1'b1, prot)
        pulse(1210);
        `chk("clear", 1'b0, prot)
        wb(8'h00, 1'b1, 32'h0400);
        wait_n(3);
        `chk("pin2 inv", 1'b0, pin_w[1])
        do_trip;
        `chk("pin2 inv", 1'b1, pin_w[1])
        pulse(1210);
        for (i = 0; i < 4; i++) begin
            wb(8'h00, 1'b1, (2 + (i & 2) * 2 + (i & 1) * 8) * 257);
            wait_n(3);
            `chk("out", {2{lvl(i[1], i[0])}}, pin_w)
        end
        for (i = 0; i < 2; i++) begin
            wb(8'h00, 1'b1, (1 + 4 * i) * 257);
            wait_n(4);
            wb(8'h14, 1'b0, 32'h0);
            `chk("in", {2{~i[0]}}, q[2:1])
        end
        // Random period and duty; pin one inverted to see both polarities
        p = 4 + $urandom % 12;
        d = 1 + $urandom % (p - 1);
        for (i = 4; i < 20; i += 4) wb(i[7:0], 1'b1, (i & 4) ? p : d);
        wb(8'h00, 1'b1, 32'h1216);
        wait_n(2 * p);
        n = 0;
        k = 0;
        repeat (p) begin
            @(posedge clk_i);
            n += !pin_w[1];
            k += pin_w[0];
        end
        `chk("pwm", d, n)
        `chk("pwm inv", d, k)
        end_of_test;
    end
endmodule // testbench

// [hw/pdio_consts.vh]
// Functional notes
// - Undriven normal input reads value 1
// - Undriven inverted input reads value 0
// - Invert flips incoming and outgoing signals
// - Output true drives low, inverted high
// - Output false drives high, inverted low
// - Output mode may drive configurable PWM
// - Valid pulse on pin one clears protection
// - Valid pulse stays low thirty microseconds
// - Pulse out when unprotected switch turns on
// - Pin two high while not protected
// - Pin two low while protected
// - Inverted pin two gives opposite levels
// - Pulses idle high, active part low
`ifndef PDIO_CONSTS_VH
`define PDIO_CONSTS_VH

`define PDIO_CLK_HZ 40000000
`define PDIO_PULSE_MIN_NS 30000

`define PDIO_ADDR_CTRL 8'h00
`define PDIO_ADDR_PERIOD1 8'h04
`define PDIO_ADDR_DUTY1 8'h08
`define PDIO_ADDR_PERIOD2 8'h0c
`define PDIO_ADDR_DUTY2 8'h10
`define PDIO_ADDR_STATUS 8'h14

`define PDIO_CTRL_RESET 32'h00000000
`define PDIO_CTRL_STRIDE 8
`define PDIO_F_MODE 0
`define PDIO_F_INV 2
`define PDIO_F_OSEL 3

`define PDIO_MODE_DEFAULT 2'h0
`define PDIO_MODE_INPUT 2'h1
`define PDIO_MODE_OUTPUT 2'h2

`define PDIO_OSEL_FALSE 2'h0
`define PDIO_OSEL_TRUE 2'h1
`define PDIO_OSEL_PWM 2'h2

`define PDIO_ST_PROT 0
`define PDIO_ST_IN1 1
`define PDIO_ST_IN2 2
`define PDIO_ST_PULSE 3

`endif

// [hw/pdio_top.v]
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "pdio_consts.vh"

module pdio_top #(
    parameter PWM_W = 24
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire prot_trip_i,
    input wire on_switch_i,
    output wire prot_active_o,
    output reg prot_clear_o,
    input wire [1:0] pin_i,
    output reg [1:0] pin_o,
    output reg [1:0] pin_oe_o
);

    // Round up: a least time
    localparam [31:0] PULSE_CYC =
        (`PDIO_PULSE_MIN_NS * (`PDIO_CLK_HZ / 1000000) + 999) / 1000;
    localparam [15:0] PULSE_CNT = PULSE_CYC[15:0];

    function [31:0] pdio_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            pdio_merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    pdio_merge[b*8 +: 8] = new_v[b*8 +: 8];
                end
            end
        end
    endfunction

    // Logical 1 is the low level unless inverted
    function pdio_level;
        input logical;
        input inv;
        begin
            pdio_level = ~logical ^ inv;
        end
    endfunction

    reg [31:0] ctrl;
    reg [PWM_W-1:0] period [0:1];
    reg [PWM_W-1:0] duty [0:1];
    reg [PWM_W-1:0] pwm_cnt [0:1];
    reg [1:0] pwm_on;
    reg [1:0] sync_a;
    reg [1:0] sync_b;
    reg prot;
    reg [15:0] low_cnt;
    reg low_done;
    reg [15:0] pulse_cnt;
    reg pulse_busy;
    reg on_prev;

    wire req = wb_cyc_i & wb_stb_i;
    wire wr = req & wb_we_i & wb_ack_o;
    wire [1:0] mode1 = ctrl[`PDIO_F_MODE +: 2];
    wire inv1 = ctrl[`PDIO_F_INV];
    wire [1:0] sensed;
    wire [31:0] status;

    assign prot_active_o = prot;

    // Register index; one decoder serves the read and the write path
    localparam [2:0] REG_NONE = 3'h0;
    localparam [2:0] REG_CTRL = 3'h1;
    localparam [2:0] REG_PERIOD1 = 3'h2;
    localparam [2:0] REG_DUTY1 = 3'h3;
    localparam [2:0] REG_PERIOD2 = 3'h4;
    localparam [2:0] REG_DUTY2 = 3'h5;
    localparam [2:0] REG_STATUS = 3'h6;
    localparam [31:0] CTRL_MASK = 32'h00001f1f;

    function [2:0] pdio_decode;
        input [7:0] addr;
        begin
            case (addr)
                `PDIO_ADDR_CTRL: pdio_decode = REG_CTRL;
                `PDIO_ADDR_PERIOD1: pdio_decode = REG_PERIOD1;
                `PDIO_ADDR_DUTY1: pdio_decode = REG_DUTY1;
                `PDIO_ADDR_PERIOD2: pdio_decode = REG_PERIOD2;
                `PDIO_ADDR_DUTY2: pdio_decode = REG_DUTY2;
                `PDIO_ADDR_STATUS: pdio_decode = REG_STATUS;
                default: pdio_decode = REG_NONE;
            endcase
        end
    endfunction

    // Zero extension of a PWM setting for the bus view
    function [31:0] pdio_widen;
        input [PWM_W-1:0] v;
        begin
            pdio_widen = {{(32-PWM_W){1'b0}}, v};
        end
    endfunction

    wire [2:0] reg_idx = pdio_decode(wb_adr_i);
    wire [31:0] ctrl_merged = pdio_merge(ctrl, wb_dat_i, wb_sel_i);
    reg next_ack;
    reg [31:0] next_dat;

    // Ack one cycle after the request; the ack itself blocks a second one
    always @* begin
        next_ack = req & ~wb_ack_o;
        case (reg_idx)
            REG_CTRL: next_dat = ctrl;
            REG_PERIOD1: next_dat = pdio_widen(period[0]);
            REG_DUTY1: next_dat = pdio_widen(duty[0]);
            REG_PERIOD2: next_dat = pdio_widen(period[1]);
            REG_DUTY2: next_dat = pdio_widen(duty[1]);
            REG_STATUS: next_dat = status;
            default: next_dat = 32'h00000000;
        endcase
    end

    // Read data registered; writes land at the acked edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // Status is read only; a write to it is acked and dropped
    // Unused control bits are masked so they read back as zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `PDIO_CTRL_RESET;
        end else if (wr && reg_idx == REG_CTRL) begin
            ctrl <= ctrl_merged & CTRL_MASK;
        end
    end

    // PWM settings per pin; the bus word is wider than the counters
    // The top byte lane is cut off on purpose
    genvar r;
    generate
        for (r = 0; r < 2; r = r + 1) begin : pwm_reg
            localparam [2:0] PER_IDX = (r == 0) ? REG_PERIOD1 : REG_PERIOD2;
            localparam [2:0] DUTY_IDX = (r == 0) ? REG_DUTY1 : REG_DUTY2;
            wire [31:0] per_merged = pdio_merge(pdio_widen(period[r]), wb_dat_i, wb_sel_i);
            wire [31:0] duty_merged = pdio_merge(pdio_widen(duty[r]), wb_dat_i, wb_sel_i);

            always @(posedge clk_i) begin
                if (rst_i) begin
                    period[r] <= {PWM_W{1'b0}};
                    duty[r] <= {PWM_W{1'b0}};
                end else if (wr) begin
                    if (reg_idx == PER_IDX) begin
                        period[r] <= per_merged[PWM_W-1:0];
                    end
                    if (reg_idx == DUTY_IDX) begin
                        duty[r] <= duty_merged[PWM_W-1:0];
                    end
                end
            end
        end
    endgenerate

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : pin
            wire [1:0] mode = ctrl[g*`PDIO_CTRL_STRIDE + `PDIO_F_MODE +: 2];
            wire inv = ctrl[g*`PDIO_CTRL_STRIDE + `PDIO_F_INV];
            wire [1:0] osel = ctrl[g*`PDIO_CTRL_STRIDE + `PDIO_F_OSEL +: 2];

            // Two flops; the first is seen only by the second
            always @(posedge clk_i) begin
                if (rst_i) begin
                    sync_a[g] <= 1'b1;
                    sync_b[g] <= 1'b1;
                end else begin
                    sync_a[g] <= pin_i[g];
                    sync_b[g] <= sync_a[g];
                end
            end

            // External pull-up makes an open pin read high
            assign sensed[g] = sync_b[g] ^ inv;

            // Period 0 holds the counter, so duty alone decides the level
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pwm_cnt[g] <= {PWM_W{1'b0}};
                    pwm_on[g] <= 1'b0;
                end else begin
                    if (pwm_cnt[g] + 1'b1 >= period[g]) begin
                        pwm_cnt[g] <= {PWM_W{1'b0}};
                    end else begin
                        pwm_cnt[g] <= pwm_cnt[g] + 1'b1;
                    end
                    pwm_on[g] <= (pwm_cnt[g] < duty[g]);
                end
            end

            always @(posedge clk_i) begin
                if (rst_i) begin
                    pin_o[g] <= 1'b1;
                    pin_oe_o[g] <= 1'b0;
                end else begin
                    case (mode)
                        `PDIO_MODE_OUTPUT: begin
                            pin_oe_o[g] <= 1'b1;
                            case (osel)
                                `PDIO_OSEL_TRUE: pin_o[g] <= pdio_level(1'b1, inv);
                                `PDIO_OSEL_PWM: pin_o[g] <= pdio_level(pwm_on[g], inv);
                                default: pin_o[g] <= pdio_level(1'b0, inv);
                            endcase
                        end
                        `PDIO_MODE_DEFAULT: begin
                            if (g == 1) begin
                                // Status level: protected is logical 1
                                pin_oe_o[g] <= 1'b1;
                                pin_o[g] <= pdio_level(prot, inv);
                            end else begin
                                // Released between pulses so it can receive
                                pin_oe_o[g] <= pulse_busy;
                                pin_o[g] <= pdio_level(pulse_busy, inv);
                            end
                        end
                        default: begin
                            pin_oe_o[g] <= 1'b0;
                            pin_o[g] <= 1'b1;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Low phase qualification; our own pulse is not taken as input
    reg [15:0] next_low_cnt;
    reg next_low_done;
    wire low_armed = (mode1 == `PDIO_MODE_DEFAULT) & ~pulse_busy & ~sensed[0];

    always @* begin
        next_low_cnt = low_cnt;
        next_low_done = 1'b0;
        if (!low_armed) begin
            next_low_cnt = 16'h0000;
        end else if (low_cnt < PULSE_CNT) begin
            next_low_cnt = low_cnt + 16'h0001;
        end else begin
            // Saturate so one long low clears only once
            next_low_done = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt <= 16'h0000;
            low_done <= 1'b0;
        end else begin
            low_cnt <= next_low_cnt;
            low_done <= next_low_done;
        end
    end

    wire clear_evt = (low_cnt == PULSE_CNT) & ~low_done;
    reg next_prot;

    // A trip in the clearing cycle keeps protection set
    always @* begin
        next_prot = prot;
        if (prot_trip_i) begin
            next_prot = 1'b1;
        end else if (clear_evt) begin
            next_prot = 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            prot <= 1'b0;
            prot_clear_o <= 1'b0;
        end else begin
            prot <= next_prot;
            prot_clear_o <= clear_evt & prot & ~prot_trip_i;
        end
    end

    // Pulse out on off-to-on while unprotected
    localparam [0:0] PO_IDLE = 1'b0;
    localparam [0:0] PO_BUSY = 1'b1;
    reg next_busy;
    reg [15:0] next_pulse_cnt;
    wire switch_rise = on_switch_i & ~on_prev;

    // A rise while protected or mid-pulse is dropped, not queued
    always @* begin
        next_busy = pulse_busy;
        next_pulse_cnt = pulse_cnt;
        case (pulse_busy)
            PO_IDLE: begin
                next_pulse_cnt = 16'h0000;
                if (switch_rise && !prot && mode1 == `PDIO_MODE_DEFAULT) begin
                    next_busy = PO_BUSY;
                end
            end
            PO_BUSY: begin
                if (pulse_cnt + 16'h0001 >= PULSE_CNT) begin
                    next_busy = PO_IDLE;
                    next_pulse_cnt = 16'h0000;
                end else begin
                    next_pulse_cnt = pulse_cnt + 16'h0001;
                end
            end
            default: begin
                next_busy = PO_IDLE;
                next_pulse_cnt = 16'h0000;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            on_prev <= 1'b0;
            pulse_busy <= PO_IDLE;
            pulse_cnt <= 16'h0000;
        end else begin
            on_prev <= on_switch_i;
            pulse_busy <= next_busy;
            pulse_cnt <= next_pulse_cnt;
        end
    end

    assign status = {28'h0000000, pulse_busy, sensed[1], sensed[0], prot};

endmodule // pdio_top
